//--- logic/host_port_parallel_spi.sv
`timescale 1ns/10ps
module host_port_parallel_spi
  import hostport_pkg::*;
#(
  parameter int INT_COUNT = 8
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic BUS_STYLE_SELECT,
  input wire logic SERIAL_SELECT,
  input wire logic PORT_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic DIRECTION_LEVEL_N,
  input wire logic DATA_LATCH_STROBE_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic SERIAL_CLK,
  input wire logic SERIAL_MOSI,
  output logic SERIAL_MISO,
  output logic SERIAL_MISO_OE,
  output logic IRQ_OUT_N,
  output logic IRQ_OUT_N_OE,
  input wire logic [INT_COUNT-1:0] INT_ACTIVE,
  input wire logic [INT_COUNT-1:0] INT_MASK,
  output logic [ADDR_W-1:0] REG_ADDR,
  output logic [DATA_W-1:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA
);
  if (INT_COUNT < 1) begin : g_bad_count
    $error("INT_COUNT must be at least one");
  end

  // pin synchronisers
  logic [6:0] ctl_s;
  logic [ADDR_W+DATA_W-1:0] bus_s;
  logic [1:0] tgl_s;

  sync2 #(
    .WIDTH(7),
    .INIT(CTL_PIN_INIT)
  ) u_ctl_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d({BUS_STYLE_SELECT, SERIAL_SELECT, PORT_SELECT_N, READ_STROBE_N,
        WRITE_STROBE_N, DIRECTION_LEVEL_N, DATA_LATCH_STROBE_N}),
    .q(ctl_s)
  );

  // separate address and data pins, never shared
  sync2 #(
    .WIDTH(ADDR_W + DATA_W),
    .INIT('0)
  ) u_bus_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d({ADDR, DATA_IN}),
    .q(bus_s)
  );

  wire style_s = ctl_s[6];
  wire serial_s = ctl_s[5];
  wire cs_n_s = ctl_s[4];
  wire rd_n_s = ctl_s[3];
  wire wr_n_s = ctl_s[2];
  wire rw_n_s = ctl_s[1];
  wire ds_n_s = ctl_s[0];
  wire [ADDR_W-1:0] addr_s = bus_s[ADDR_W+DATA_W-1:DATA_W];
  wire [DATA_W-1:0] din_s = bus_s[DATA_W-1:0];

  // link reset follows system reset one REF_CLK cycle later, with no regard to the serial clock
  logic link_rst_n;

  always_ff @(posedge REF_CLK) begin
    link_rst_n <= RSTN;
  end

  // serial link on its own clock
  logic [CTRL_W-1:0] ctrl_word;
  logic [DATA_W-1:0] data_word;
  logic ctrl_tgl;
  logic data_tgl;
  logic [DATA_W-1:0] tx_byte;

  // straps steer the clock tree directly; they are static pins, so
  // no synchroniser belongs on them
  wire sample_clk = SERIAL_CLK ^ DATA_IN[CPOL_PIN] ^ DATA_IN[CPHA_PIN];

  spi_link u_link (
    .sample_clk(sample_clk),
    .cs_n(PORT_SELECT_N),
    .rst_n(link_rst_n),
    .mosi(SERIAL_MOSI),
    .tx_byte(tx_byte),
    .ctrl_word(ctrl_word),
    .ctrl_tgl(ctrl_tgl),
    .data_word(data_word),
    .data_tgl(data_tgl),
    .miso(SERIAL_MISO)
  );

  sync2 #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_tgl_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .d({ctrl_tgl, data_tgl}),
    .q(tgl_s)
  );

  // parallel port decode
  wire par_on = ~serial_s & ~cs_n_s;
  wire style_ds = (style_s != SPLIT_STYLE);
  wire ds_read = ~ds_n_s & rw_n_s;
  wire ds_write = ~ds_n_s & ~rw_n_s;
  wire rd_req = par_on & (style_ds ? ds_read : ~rd_n_s);
  wire wr_req = par_on & (style_ds ? ds_write : ~wr_n_s);

  par_state_t pstate;
  par_state_t next_pstate;
  logic [ADDR_W-1:0] par_addr;
  logic [DATA_W-1:0] par_data;

  // read wins if both split strobes drop together
  always_comb begin
    next_pstate = pstate;
    case (pstate)
      P_IDLE: begin
        if (rd_req) begin
          next_pstate = P_READ;
        end else if (wr_req) begin
          next_pstate = P_WRITE;
        end
      end
      P_READ: begin
        if (!rd_req) begin
          next_pstate = P_IDLE;
        end
      end
      P_WRITE: begin
        if (!wr_req) begin
          next_pstate = P_IDLE;
        end
      end
      default: begin
        next_pstate = P_IDLE;
      end
    endcase
  end

  wire par_rd_go = (pstate == P_IDLE) & rd_req;
  wire par_wr_go = (pstate == P_WRITE) & ~wr_req;
  wire par_latch = wr_req & (pstate != P_READ);

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      pstate <= P_IDLE;
      par_addr <= '0;
      par_data <= '0;
    end else begin
      pstate <= next_pstate;
      // data tracks the pins until the strobe rises
      if (par_latch) begin
        par_addr <= addr_s;
        par_data <= din_s;
      end
    end
  end

  // serial command decode
  logic ctrl_seen;
  logic data_seen;
  logic spi_rw;
  logic spi_burst;
  logic [ADDR_W-1:0] spi_addr;

  wire ctrl_evt = tgl_s[1] ^ ctrl_seen;
  wire data_evt = tgl_s[0] ^ data_seen;
  wire lsb_first = (din_s[ORDER_PIN] == LSB_FIRST_LEVEL);

  wire [ADDR_W-1:0] cw_addr_raw = ctrl_word[CTRL_W-2:BURST_POS+1];
  wire [ADDR_W-1:0] cw_addr_rev = {<<{cw_addr_raw}};
  wire [ADDR_W-1:0] cw_addr = lsb_first ? cw_addr_rev : cw_addr_raw;
  wire cw_read = (ctrl_word[RW_POS] == RW_READ);
  wire cw_burst = ctrl_word[BURST_POS];

  wire [DATA_W-1:0] dw_rev = {<<{data_word}};
  wire [DATA_W-1:0] spi_data = lsb_first ? dw_rev : data_word;
  wire [ADDR_W-1:0] spi_next_addr = spi_addr + 14'h0001;

  wire spi_ctrl_rd = ctrl_evt & cw_read;
  wire spi_burst_rd = ~ctrl_evt & data_evt & spi_rw & spi_burst;
  wire spi_rd_go = serial_s & (spi_ctrl_rd | spi_burst_rd);
  wire spi_wr_go = serial_s & ~ctrl_evt & data_evt & ~spi_rw;
  wire [ADDR_W-1:0] spi_rd_addr = ctrl_evt ? cw_addr : spi_next_addr;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      // adopt the link toggles so reset never fakes an event
      ctrl_seen <= tgl_s[1];
      data_seen <= tgl_s[0];
      spi_rw <= 1'b0;
      spi_burst <= 1'b0;
      spi_addr <= '0;
    end else begin
      ctrl_seen <= tgl_s[1];
      data_seen <= tgl_s[0];
      if (ctrl_evt) begin
        spi_rw <= cw_read;
        spi_burst <= cw_burst;
        spi_addr <= cw_addr;
      end else if (data_evt && spi_burst) begin
        spi_addr <= spi_next_addr;
      end
    end
  end

  // register access toward the core
  wire next_reg_rd = par_rd_go | spi_rd_go;
  wire next_reg_wr = par_wr_go | spi_wr_go;
  wire [ADDR_W-1:0] spi_bus_addr = spi_wr_go ? spi_addr : spi_rd_addr;
  wire [ADDR_W-1:0] par_bus_addr = par_rd_go ? addr_s : par_addr;
  wire [ADDR_W-1:0] next_reg_addr = serial_s ? spi_bus_addr : par_bus_addr;
  wire [DATA_W-1:0] next_reg_wdata = serial_s ? spi_data : par_data;

  logic [DATA_W-1:0] rd_data;
  wire [DATA_W-1:0] rd_data_rev = {<<{rd_data}};

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      REG_RD <= 1'b0;
      REG_WR <= 1'b0;
      REG_ADDR <= '0;
      REG_WDATA <= '0;
      rd_data <= '0;
    end else begin
      REG_RD <= next_reg_rd;
      REG_WR <= next_reg_wr;
      if (next_reg_rd || next_reg_wr) begin
        REG_ADDR <= next_reg_addr;
        REG_WDATA <= next_reg_wdata;
      end
      if (REG_RD) begin
        rd_data <= REG_RDATA;
      end
    end
  end

  // the link shifts this static byte; the master leaves a gap before
  // the data byte of a read so the crossing has settled
  assign tx_byte = lsb_first ? rd_data_rev : rd_data;
  assign DATA_OUT = rd_data;
  assign DATA_OE = (pstate == P_READ);
  assign SERIAL_MISO_OE = serial_s & ~cs_n_s;

  // interrupt: open drain, only ever pulls low
  logic irq_q;

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(INT_ACTIVE & ~INT_MASK);
    end
  end

  assign IRQ_OUT_N = 1'b0;
  assign IRQ_OUT_N_OE = irq_q;
endmodule

//--- logic/hostport_pkg.sv
// Overview of operation
// - 8-bit data; style pin picks strobe style
// - 14 address inputs decode whole space
// - no multiplexed address/data, separate pins
// - split style: read and write strobes
// - direction level plus separate data strobe
// - open-drain irq low on unmasked condition
// - serial select high gives four-wire serial
// - data pins 7/6 strap polarity/phase
// - data pin 5 sets bit order
// - rw flag first, burst flag last
// - select may toggle or stay low
// - burst: no more control, address increments
// - no burst: control bytes follow data
// - select high ends burst, control next
package hostport_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int CTRL_W = 16;
  localparam int RW_POS = 15;
  localparam int BURST_POS = 0;
  localparam int CPOL_PIN = 7;
  localparam int CPHA_PIN = 6;
  localparam int ORDER_PIN = 5;
  localparam logic SPLIT_STYLE = 1'b0;
  localparam logic LSB_FIRST_LEVEL = 1'b1;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] CTRL_LAST = 4'hF;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [6:0] CTL_PIN_INIT = 7'h1F;
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_READ = 2'b01,
    P_WRITE = 2'b10
  } par_state_t;
endpackage

//--- logic/spi_link.sv
`timescale 1ns/10ps
module spi_link
  import hostport_pkg::*;
(
  input wire logic sample_clk,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic mosi,
  input wire logic [DATA_W-1:0] tx_byte,
  output logic [CTRL_W-1:0] ctrl_word,
  output logic ctrl_tgl,
  output logic [DATA_W-1:0] data_word,
  output logic data_tgl,
  output logic miso
);
  logic [3:0] cnt;
  logic in_data;
  logic burst;
  logic [CTRL_W-2:0] sh;
  wire clr = cs_n | ~rst_n;
  wire ctrl_end = !in_data && (cnt == CTRL_LAST);
  wire data_end = in_data && (cnt == DATA_LAST);
  wire [3:0] tx_idx = DATA_LAST - cnt;

  // bits leave msb first; the core pre-reverses for lsb-first order
  assign miso = in_data ? tx_byte[tx_idx[2:0]] : 1'b0;

  // select high clears framing, so the next byte is control
  always_ff @(posedge sample_clk or posedge clr) begin
    if (clr) begin
      cnt <= 4'h0;
      in_data <= 1'b0;
      burst <= 1'b0;
    end else begin
      cnt <= (ctrl_end || data_end) ? 4'h0 : cnt + 4'h1;
      if (ctrl_end) begin
        in_data <= 1'b1;
        burst <= mosi;
      end else if (data_end) begin
        in_data <= burst;
      end
    end
  end

  // toggles survive select changes so no false event is seen
  always_ff @(posedge sample_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '0;
      ctrl_word <= '0;
      data_word <= '0;
      ctrl_tgl <= 1'b0;
      data_tgl <= 1'b0;
    end else begin
      sh <= {sh[CTRL_W-3:0], mosi};
      if (ctrl_end) begin
        ctrl_word <= {sh, mosi};
        ctrl_tgl <= ~ctrl_tgl;
      end
      if (data_end) begin
        data_word <= {sh[DATA_W-2:0], mosi};
        data_tgl <= ~data_tgl;
      end
    end
  end
endmodule

//--- logic/sync2.sv
`timescale 1ns/10ps
module sync2
  import hostport_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- tb/host_port_parallel_spi_bench.sv
`timescale 1ns/10ps
module host_port_parallel_spi_bench
  import hostport_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, bus_style_select = 1'b0, ss = 1'b0, cs_n = 1'b1;
  logic rd_n = 1'b1, wr_n = 1'b1, dir_n = 1'b1, ds_n = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [ADDR_W-1:0] raddr, wa, ra;
  logic [DATA_W-1:0] din = '0;
  logic [DATA_W-1:0] dout, wdata, rdata, wd;
  logic [7:0] act = '0, msk = '0;
  logic doe, sclk, mosi, miso, miso_oe, irq, irq_oe, wr, rd;
  int fails = 0, n_tests = 0, nwr = 0, nrd = 0;
  always #25 clk = ~clk;
  assign rdata = raddr[7:0] ^ 8'h5A;
  always @(posedge clk) begin
    if (wr) begin
      wa <= raddr;
      wd <= wdata;
      nwr <= nwr + 1;
    end
    if (rd) begin
      ra <= raddr;
      nrd <= nrd + 1;
    end
  end
  host_port_parallel_spi DUT (.REF_CLK(clk), .RSTN(rstn), .BUS_STYLE_SELECT(bus_style_select), .SERIAL_SELECT(ss),
    .PORT_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .DIRECTION_LEVEL_N(dir_n),
    .DATA_LATCH_STROBE_N(ds_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .SERIAL_CLK(sclk), .SERIAL_MOSI(mosi), .SERIAL_MISO(miso), .SERIAL_MISO_OE(miso_oe),
    .IRQ_OUT_N(irq), .IRQ_OUT_N_OE(irq_oe), .INT_ACTIVE(act), .INT_MASK(msk), .REG_ADDR(raddr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata));
  spi_master_model u_host (.cpol(din[7]), .cpha(din[6]), .miso(miso), .sclk(sclk), .mosi(mosi));
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_cnt(ref int c, input int old);
    for (int k = 0; k < 40 && c == old; k++) tick(1);
    if (c == old) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic pwr(input logic [13:0] a, input logic [7:0] d);
    int old;
    old = nwr;
    addr = a;
    din = d;
    cs_n = 0;
    dir_n = !bus_style_select;
    ds_n = !bus_style_select;
    wr_n = bus_style_select;
    tick(6);
    ds_n = 1;
    wr_n = 1;
    wait_cnt(nwr, old);
    cs_n = 1;
    dir_n = 1;
    check(wa, a);
    check(wd, d);
    tick(3);
  endtask
  task automatic prd(input logic [13:0] a);
    int old;
    old = nrd;
    addr = a;
    cs_n = 0;
    ds_n = !bus_style_select;
    rd_n = bus_style_select;
    wait_cnt(nrd, old);
    tick(2);
    check(doe, 1);
    check(dout, a[7:0] ^ 8'h5A);
    check(ra, a);
    rd_n = 1;
    ds_n = 1;
    tick(4);
    check(doe, 0);
    cs_n = 1;
    tick(3);
  endtask
  task automatic sacc(input logic ctl, input logic rw, input logic [13:0] a, input logic b, input logic [7:0] d);
    logic [7:0] i;
    logic [15:0] c;
    logic [13:0] ar;
    logic [7:0] dr, ir;
    int o1, o2;
    o1 = nwr;
    o2 = nrd;
    ar = a;
    if (din[5]) ar = {<<{a}};
    dr = d;
    if (din[5]) dr = {<<{d}};
    c = {rw, ar, b};
    if (cs_n) tick(1);
    cs_n = 0;
    if (ctl) u_host.xfer(c[15:8], i);
    if (ctl) u_host.xfer(c[7:0], i);
    if (rw) wait_cnt(nrd, o2);
    if (rw) check(ra, a);
    if (rw) tick(4);
    u_host.xfer(dr, i);
    ir = i;
    if (din[5]) ir = {<<{i}};
    if (rw) check(ir, a[7:0] ^ 8'h5A);
    if (!rw) wait_cnt(nwr, o1);
    if (!rw) check(wa, a);
    if (!rw) check(wd, d);
    tick(8);
  endtask
  initial begin
    int old;
    tick(20);
    rstn = 1;
    tick(3);
    act = 8'h10;
    msk = 8'h10;
    tick(3);
    check(irq_oe, 0);
    msk = 8'h00;
    tick(3);
    check(irq_oe, 1);
    check(irq, 0);
    for (int s = 0; s < 2; s++) begin
      bus_style_select = s[0];
      tick(3);
      pwr(14'h2A5C, 8'hC3);
      pwr(14'h3FFF, 8'h00);
      prd(14'h1234);
      prd(14'h0001);
    end
    bus_style_select = 0;
    tick(3);
    old = nwr;
    wr_n = 0;
    tick(6);
    wr_n = 1;
    tick(6);
    check(nwr, old);
    ss = 1;
    tick(4);
    for (int m = 0; m < 8; m++) begin
      din[7:5] = m[2:0];
      tick(2);
      sacc(1, ~RW_READ, 14'h0A00 + m, 0, 8'h90 + m);
      sacc(1, RW_READ, 14'h2001, 0, 8'h00);
      cs_n = 1;
      tick(4);
    end
    sacc(1, ~RW_READ, 14'h3FFE, 1, 8'h11);
    sacc(0, ~RW_READ, 14'h3FFF, 1, 8'h22);
    cs_n = 1;
    tick(4);
    sacc(1, ~RW_READ, 14'h0100, 0, 8'h33);
    print_verdict();
  end
endmodule

//--- tb/hostport_props.sv
`timescale 1ns/10ps
module hostport_props
  import hostport_pkg::*;
#(
  parameter int INT_COUNT = 8
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic BUS_STYLE_SELECT,
  input wire logic SERIAL_SELECT,
  input wire logic PORT_SELECT_N,
  input wire logic READ_STROBE_N,
  input wire logic [DATA_W-1:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic SERIAL_MISO_OE,
  input wire logic IRQ_OUT_N_OE,
  input wire logic [INT_COUNT-1:0] INT_ACTIVE,
  input wire logic [INT_COUNT-1:0] INT_MASK,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);
  a_wr_one_cycle: assert property (REG_WR |=> !REG_WR) else $error("write pulse too long");
  a_rd_one_cycle: assert property (REG_RD |=> !REG_RD) else $error("read pulse too long");
  a_rd_data_out: assert property (REG_RD |=> DATA_OUT == $past(REG_RDATA)) else $error("read data lost");
  a_rd_drives_bus: assert property ((!SERIAL_SELECT)[*4] ##0 REG_RD |-> DATA_OE) else $error("bus not driven");
  a_oe_release: assert property (!SERIAL_SELECT && !BUS_STYLE_SELECT && $rose(READ_STROBE_N)
    |-> ##[2:4] !DATA_OE) else $error("bus not released");
  a_cs_ignored: assert property (PORT_SELECT_N[*4] ##0 !SERIAL_SELECT |-> !REG_RD) else $error("read unselected");
  a_serial_quiet: assert property (SERIAL_SELECT[*4] |-> !DATA_OE) else $error("bus driven in serial");
  a_miso_on: assert property ((SERIAL_SELECT && !PORT_SELECT_N)[*4] |-> SERIAL_MISO_OE) else $error("miso off");
  a_miso_off: assert property ((!SERIAL_SELECT || PORT_SELECT_N)[*4] |-> !SERIAL_MISO_OE) else $error("miso on");
  a_irq_follow: assert property ($past(RSTN) |-> IRQ_OUT_N_OE == |$past(INT_ACTIVE & ~INT_MASK))
    else $error("irq wrong");
endmodule
bind host_port_parallel_spi hostport_props #(.INT_COUNT(INT_COUNT)) u_props (.*);

//--- tb/spi_master_model.sv
`timescale 1ns/10ps
module spi_master_model (
  input wire logic cpol,
  input wire logic cpha,
  input wire logic miso,
  output logic sclk,
  output logic mosi
);
  logic busy = 1'b0;
  initial sclk = 1'b0;
  initial mosi = 1'b0;
  // slave only: clock stands at idle level between frames
  always @(cpol or busy) if (!busy) sclk = cpol;
  task automatic xfer(input logic [7:0] o, output logic [7:0] i);
    busy = 1'b1;
    for (int b = 7; b >= 0; b--) begin
      if (!cpha) mosi = o[b];
      #6;
      // miso is taken just before the edge that moves it, in the same time step as that edge
      if (!cpha) i[b] = miso;
      sclk = ~cpol;
      if (cpha) mosi = o[b];
      #6;
      if (cpha) i[b] = miso;
      sclk = cpol;
    end
    // no stale bit left on a line nobody samples
    #6 mosi = ~mosi;
    busy = 1'b0;
  endtask
endmodule
